// file: rtl/dxc_map.svh
`ifndef DXC_MAP_SVH
`define DXC_MAP_SVH
// Function
// - Write to 0018h loads command select
// - Select write clears byte pointer
// - Command bits 7-4, channel 2-0, bit3 zero
// - Execute port access runs command, advances pointer
// - Mask set, clear, master clear act immediately
// - Each channel keeps readable, writable transfer mode
// - Mode bit 6 selects 8 or 16 bits
// - Host matches width to slave size; dxc_host passes mode bit 6 as written
// - Bit3 picks direction, bit2 verify or transfer
// - Bit0 drives zero or programmed I/O address
// - Commands 2,3 memory address; 0 I/O address
// - Commands 4,5 count; 6,7,8 byte registers
// - Commands 9, A mask bit; D master clear; others reserved
// - Channels 0 and 4 hold arbitration level
// - Host never programs arbitration level F
// - Arbitration command uses channel 0 or 4
// - Setup order: mask, address, count, mode, unmask
// - Mask blocks service; reset sets all masks
// - Count plus one transfers; wrap raises TC
// - Status set by events, cleared by read

// Host I/O port addresses
`define DXC_PORT_SEL 16'h0018
`define DXC_PORT_EXEC 16'h001A

// Command codes
`define DXC_CMD_IOADR 4'h0
`define DXC_CMD_MEMWR 4'h2
`define DXC_CMD_MEMRD 4'h3
`define DXC_CMD_CNTWR 4'h4
`define DXC_CMD_CNTRD 4'h5
`define DXC_CMD_STAT 4'h6
`define DXC_CMD_MODE 4'h7
`define DXC_CMD_ARB 4'h8
`define DXC_CMD_MSET 4'h9
`define DXC_CMD_MCLR 4'hA
`define DXC_CMD_MCLEAR 4'hD

// Transfer mode bit positions
`define DXC_MODE_WIDE 6
`define DXC_MODE_WRMEM 3
`define DXC_MODE_XFER 2
`define DXC_MODE_USEIO 0
`define DXC_MODE_KEEP 8'h4D
`define DXC_ARB_RSVD 4'hF

// Reset values
`define DXC_MASK_RST 8'hFF
`define DXC_IO_ZERO 16'h0000

// Host command-port register offsets
`define DXC_H_SEL 2'h0
`define DXC_H_EXEC 2'h1
`define DXC_H_IN 2'h2
`define DXC_H_STAT 2'h3
`endif

// file: rtl/dxc_pkg.sv
package dxc_pkg;

  typedef struct packed {
    logic [3:0] cmd;
    logic [2:0] chan;
    logic [1:0] ptr;
    logic [7:0] mask;
    logic [7:0][15:0] ioAdr;
    logic [7:0][23:0] memAdr;
    logic [7:0][15:0] cnt;
    logic [7:0][15:0] cur;
    logic [7:0][7:0] mode;
    logic [1:0][3:0] arb;
    logic [1:0][7:0] status;
    logic [7:0] rdData;
    logic xferStrobe;
    logic [2:0] xferChan;
    logic [23:0] xferMemAddr;
    logic [15:0] xferIoAddr;
    logic xferWide;
    logic xferWriteMem;
    logic xferVerify;
    logic [3:0] arbId;
    logic tcPulse;
  } dxc_dev_state_t;

  typedef enum logic [1:0] {HS_IDLE, HS_RDREQ, HS_CAPT} dxc_hstate_t;

  typedef struct packed {
    dxc_hstate_t st;
    logic [15:0] ioAddr;
    logic [7:0] ioWrData;
    logic ioWr;
    logic ioRd;
    logic [3:0] lastCmd;
    logic selSeen;
    logic [7:0] inData;
    logic err;
    logic [7:0] rdData;
  } dxc_host_state_t;

endpackage : dxc_pkg

// file: rtl/dxc_if.sv
`timescale 1ns/1ps
// Host I/O bus between processor end and controller end
interface dxc_if;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData;
  logic ioWr;
  logic ioRd;
  logic [7:0] ioRdData;

  modport dev (input ioAddr, input ioWrData, input ioWr, input ioRd,
    output ioRdData);
  modport host (output ioAddr, output ioWrData, output ioWr,
    output ioRd, input ioRdData);
endinterface : dxc_if

// file: rtl/dxc_host.sv
`timescale 1ns/1ps
`include "dxc_map.svh"
// Processor end: turns command-port writes into I/O bus cycles
module dxc_host
  import dxc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  dxc_if.host bus,
  input wire logic [1:0] cmdAddr,
  input wire logic [7:0] cmdWrData,
  input wire logic cmdWr,
  input wire logic cmdRd,
  output logic [7:0] cmdRdData
);

  dxc_host_state_t s;
  dxc_host_state_t next_s;

  assign bus.ioAddr = s.ioAddr;
  assign bus.ioWrData = s.ioWrData;
  assign bus.ioWr = s.ioWr;
  assign bus.ioRd = s.ioRd;
  assign cmdRdData = s.rdData;

  // One bus cycle per accepted order; a read holds off new orders
  always_comb begin
    next_s = s;
    next_s.ioWr = 1'b0;
    next_s.ioRd = 1'b0;
    next_s.rdData = 8'h00;
    if (cmdRd) begin
      case (cmdAddr)
        `DXC_H_EXEC: next_s.rdData = s.inData;
        `DXC_H_STAT: next_s.rdData = {5'h00, s.err, s.selSeen,
          s.st != HS_IDLE};
        default: next_s.rdData = 8'h00;
      endcase
    end
    case (s.st)
      HS_IDLE: begin
        if (cmdWr) begin
          case (cmdAddr)
            `DXC_H_SEL: begin
              if (cmdWrData[7:4] == `DXC_CMD_ARB &&
                  cmdWrData[1:0] != 2'h0) begin
                next_s.err = 1'b1;
              end else begin
                next_s.ioWr = 1'b1;
                next_s.ioAddr = `DXC_PORT_SEL;
                // Bit 3 forced low, command high, channel low
                next_s.ioWrData = {cmdWrData[7:4], 1'b0,
                  cmdWrData[2:0]};
                next_s.lastCmd = cmdWrData[7:4];
                next_s.selSeen = 1'b1;
              end
            end
            `DXC_H_EXEC: begin
              // Execute before any select means setup is out of order
              if (!s.selSeen) begin
                next_s.err = 1'b1;
              end else if (s.lastCmd == `DXC_CMD_ARB &&
                  cmdWrData[3:0] == `DXC_ARB_RSVD) begin
                next_s.err = 1'b1;
              end else begin
                next_s.ioWr = 1'b1;
                next_s.ioAddr = `DXC_PORT_EXEC;
                // Width bit passes untouched, software owns it
                next_s.ioWrData = (s.lastCmd == `DXC_CMD_MODE) ?
                  (cmdWrData & `DXC_MODE_KEEP) :
                  cmdWrData;
              end
            end
            `DXC_H_IN: begin
              if (!s.selSeen) begin
                next_s.err = 1'b1;
              end else begin
                next_s.ioRd = 1'b1;
                next_s.ioAddr = `DXC_PORT_EXEC;
                next_s.st = HS_RDREQ;
              end
            end
            default: next_s.err = 1'b0;
          endcase
        end
      end
      HS_RDREQ: begin
        if (cmdWr) next_s.err = 1'b1;
        next_s.st = HS_CAPT;
      end
      HS_CAPT: begin
        if (cmdWr) next_s.err = 1'b1;
        next_s.inData = bus.ioRdData;
        next_s.st = HS_IDLE;
      end
      default: next_s.st = HS_IDLE;
    endcase
    if (!rst_b) begin
      next_s = '0;
      next_s.st = HS_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

endmodule : dxc_host

// file: rtl/dxc_dev.sv
`timescale 1ns/1ps
`include "dxc_map.svh"
// Controller end: extended command decode plus a simple transfer engine
module dxc_dev
  import dxc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  dxc_if.dev bus,
  input wire logic [7:0] chanReq,
  output logic xferStrobe,
  output logic [2:0] xferChan,
  output logic [23:0] xferMemAddr,
  output logic [15:0] xferIoAddr,
  output logic xferWide,
  output logic xferWriteMem,
  output logic xferVerify,
  output logic [3:0] arbId,
  output logic terminalCountFlag,
  output logic [7:0] chanMask
);

  dxc_dev_state_t s;
  dxc_dev_state_t next_s;

  // Byte pick, pointer zero is the low byte
  function automatic logic [7:0] byteOf(input logic [23:0] v,
      input logic [1:0] p);
    case (p)
      2'h0: byteOf = v[7:0];
      2'h1: byteOf = v[15:8];
      2'h2: byteOf = v[23:16];
      default: byteOf = 8'h00;
    endcase
  endfunction : byteOf

  // Byte replace; pointer past the top leaves the value alone
  function automatic logic [23:0] putByte(input logic [23:0] v,
      input logic [1:0] p, input logic [7:0] b);
    logic [23:0] r;
    r = v;
    case (p)
      2'h0: r[7:0] = b;
      2'h1: r[15:8] = b;
      2'h2: r[23:16] = b;
      default: r = v;
    endcase
    putByte = r;
  endfunction : putByte

  logic selWr;
  logic execHit;
  logic [2:0] ch;
  logic grp;
  logic found;
  logic [2:0] pick;
  logic [23:0] tmp;

  assign selWr = bus.ioWr && bus.ioAddr == `DXC_PORT_SEL;
  assign execHit = (bus.ioWr || bus.ioRd) &&
    bus.ioAddr == `DXC_PORT_EXEC;
  assign ch = s.chan;
  assign grp = s.chan[2];

  assign bus.ioRdData = s.rdData;
  assign xferStrobe = s.xferStrobe;
  assign xferChan = s.xferChan;
  assign xferMemAddr = s.xferMemAddr;
  assign xferIoAddr = s.xferIoAddr;
  assign xferWide = s.xferWide;
  assign xferWriteMem = s.xferWriteMem;
  assign xferVerify = s.xferVerify;
  assign arbId = s.arbId;
  assign terminalCountFlag = s.tcPulse;
  assign chanMask = s.mask;

  // Host decode first, then transfer events so hardware sets win
  always_comb begin
    next_s = s;
    tmp = 24'h000000;
    found = 1'b0;
    pick = 3'h0;
    next_s.rdData = 8'h00;
    next_s.xferStrobe = 1'b0;
    next_s.tcPulse = 1'b0;
    if (selWr) begin
      next_s.cmd = bus.ioWrData[7:4];
      next_s.chan = bus.ioWrData[2:0];
      next_s.ptr = 2'h0;
      // Direct commands act on the select write itself
      case (bus.ioWrData[7:4])
        // Single mask set acts at once
        `DXC_CMD_MSET: next_s.mask[bus.ioWrData[2:0]] = 1'b1;
        `DXC_CMD_MCLR: next_s.mask[bus.ioWrData[2:0]] = 1'b0;
        `DXC_CMD_MCLEAR: begin
          next_s.mask = `DXC_MASK_RST;
          next_s.status = '0;
        end
        default: next_s.mask = s.mask; // Reserved codes do nothing
      endcase
    end else if (execHit) begin
      // Pointer stops at 3, so runaway accesses never wrap to byte 0
      if (s.ptr != 2'h3) next_s.ptr = s.ptr + 2'h1;
      case (s.cmd)
        `DXC_CMD_IOADR: begin
          if (bus.ioWr) begin
            tmp = putByte({8'h00, s.ioAdr[ch]}, s.ptr, bus.ioWrData);
            next_s.ioAdr[ch] = tmp[15:0];
          end else begin
            next_s.rdData = byteOf({8'h00, s.ioAdr[ch]}, s.ptr);
          end
        end
        `DXC_CMD_MEMWR: begin
          if (bus.ioWr) next_s.memAdr[ch] =
            putByte(s.memAdr[ch], s.ptr, bus.ioWrData);
        end
        `DXC_CMD_MEMRD: begin
          if (bus.ioRd) next_s.rdData =
            byteOf(s.memAdr[ch], s.ptr);
        end
        `DXC_CMD_CNTWR: begin
          if (bus.ioWr) begin
            tmp = putByte({8'h00, s.cnt[ch]}, s.ptr, bus.ioWrData);
            next_s.cnt[ch] = tmp[15:0];
            next_s.cur[ch] = tmp[15:0];
          end
        end
        `DXC_CMD_CNTRD: begin
          if (bus.ioRd) next_s.rdData =
            byteOf({8'h00, s.cnt[ch]}, s.ptr);
        end
        `DXC_CMD_STAT: begin
          if (bus.ioRd) begin
            next_s.rdData = s.status[grp];
            next_s.status[grp] = 8'h00;
          end
        end
        `DXC_CMD_MODE: begin
          if (bus.ioWr) next_s.mode[ch] = bus.ioWrData;
          else next_s.rdData = s.mode[ch];
        end
        `DXC_CMD_ARB: begin
          // Only channels 0 and 4 own a level
          if (ch[1:0] == 2'h0) begin
            if (bus.ioWr) next_s.arb[grp] = bus.ioWrData[3:0];
            else next_s.rdData = {4'h0, s.arb[grp]};
          end
        end
        default: next_s.rdData = 8'h00;
      endcase
    end

    // Lowest unmasked requesting channel wins one transfer per cycle
    for (int i = 7; i >= 0; i--) begin
      if (chanReq[i] && !s.mask[i]) begin
        found = 1'b1;
        pick = 3'(i);
      end
    end
    if (found) begin
      next_s.xferStrobe = 1'b1;
      next_s.xferChan = pick;
      next_s.xferMemAddr = s.memAdr[pick];
      next_s.xferWide = s.mode[pick][`DXC_MODE_WIDE];
      next_s.xferWriteMem = s.mode[pick][`DXC_MODE_WRMEM];
      next_s.xferVerify = !s.mode[pick][`DXC_MODE_XFER];
      next_s.xferIoAddr = s.mode[pick][`DXC_MODE_USEIO] ?
        s.ioAdr[pick] : `DXC_IO_ZERO;
      // Channels other than 0 and 4 answer with their own number
      next_s.arbId = (pick[1:0] == 2'h0) ? s.arb[pick[2]] :
        {1'b0, pick};
      next_s.memAdr[pick] = s.memAdr[pick] +
        (s.mode[pick][`DXC_MODE_WIDE] ? 24'h000002 : 24'h000001);
      next_s.status[pick[2]][{1'b1, pick[1:0]}] = 1'b1;
      if (s.cur[pick] == 16'h0000) begin
        // Wrap to FFFF ends the block; reload and mask to stop it
        next_s.tcPulse = 1'b1;
        next_s.status[pick[2]][{1'b0, pick[1:0]}] = 1'b1;
        next_s.cur[pick] = s.cnt[pick];
        next_s.mask[pick] = 1'b1;
      end else begin
        next_s.cur[pick] = s.cur[pick] - 16'h0001;
      end
    end

    if (!rst_b) begin
      next_s = '0;
      next_s.mask = `DXC_MASK_RST;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

endmodule : dxc_dev

// file: tb/dxc_chk_sva.sv
`timescale 1ns/1ps
// Bus-level checks between the processor end and the controller end
module dxc_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioRdData
);
  logic [3:0] lastCmd;
  logic [1:0] ptr;
  logic sel;
  logic exe;
  assign sel = ioWr && ioAddr == 16'h0018;
  assign exe = (ioWr || ioRd) && ioAddr == 16'h001A;
  // Shadow pointer saturates like the device, so ptr 3 means past the end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lastCmd <= 4'h0;
      ptr <= 2'h0;
    end else if (sel) begin
      lastCmd <= ioWrData[7:4];
      ptr <= 2'h0;
    end else if (exe && ptr != 2'h3) begin
      ptr <= ptr + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_excl; !(ioWr && ioRd); endproperty
  a_excl: assert property (p_excl) else $error("both strobes high");
  property p_addr; (ioWr || ioRd) |-> sel || exe; endproperty
  a_addr: assert property (p_addr) else $error("bad port address");
  property p_rdaddr; ioRd |-> ioAddr == 16'h001A; endproperty
  a_rdaddr: assert property (p_rdaddr) else $error("read off execute");
  property p_idle; !ioRd |=> ioRdData == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_bit3; sel |-> !ioWrData[3]; endproperty
  a_bit3: assert property (p_bit3) else $error("select bit 3 set");
  property p_arbch; sel && ioWrData[7:4] == 4'h8 |-> ioWrData[1:0] == 2'h0;
  endproperty
  a_arbch: assert property (p_arbch) else $error("level cmd channel");
  property p_arbval; exe && ioWr && lastCmd == 4'h8 |-> ioWrData[3:0] != 4'hF;
  endproperty
  a_arbval: assert property (p_arbval) else $error("level F written");
  property p_mode; exe && ioWr && lastCmd == 4'h7 |-> (ioWrData & 8'hB2) == 0;
  endproperty
  a_mode: assert property (p_mode) else $error("mode spare bits set");
  property p_rsvd;
    ioRd && lastCmd inside {4'h1, 4'hB, 4'hC, 4'hE, 4'hF}
      |=> ioRdData == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved cmd data");
  property p_ptr;
    ioRd && ptr == 2'h3 && !sel |=> $stable(ptr) && ioRdData == 0;
  endproperty
  a_ptr: assert property (p_ptr) else $error("read past register");
endmodule : dxc_chk

// file: tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin nFail++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
  logic clk = 0;
  logic rst_b = 0;
  logic [1:0] cmdAddr = 2'h0;
  logic [7:0] cmdWrData = 8'h00;
  logic cmdWr = 0;
  logic cmdRd = 0;
  logic [7:0] chanReq = 8'h00;
  logic [7:0] cmdRdData, chanMask;
  logic xferStrobe, xferWide, xferWriteMem, xferVerify, terminalCountFlag;
  logic [2:0] xferChan;
  logic [23:0] xferMemAddr;
  logic [15:0] xferIoAddr;
  logic [3:0] arbId;
  logic [23:0] xa [4];
  logic xt [4];
  int nFail = 0;
  int testsRun = 0;
  int nX = 0;
  dxc_if bus ();
  dxc_host dxc_host_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
    .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdWr(cmdWr), .cmdRd(cmdRd),
    .cmdRdData(cmdRdData));
  dxc_dev dxc_dev_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
    .chanReq(chanReq), .xferStrobe(xferStrobe), .xferChan(xferChan),
    .xferMemAddr(xferMemAddr), .xferIoAddr(xferIoAddr), .xferWide(xferWide),
    .xferWriteMem(xferWriteMem), .xferVerify(xferVerify), .arbId(arbId),
    .terminalCountFlag(terminalCountFlag), .chanMask(chanMask));
  dxc_chk dxc_chk_inst (.clk(clk), .rst_b(rst_b), .ioAddr(bus.ioAddr),
    .ioWrData(bus.ioWrData), .ioWr(bus.ioWr), .ioRd(bus.ioRd),
    .ioRdData(bus.ioRdData));
  initial forever #5 clk = ~clk;
  // Log each transfer; outputs are flops, so edge sampling is race free
  always @(posedge clk) begin
    if (xferStrobe === 1'b1) begin
      xa[nX[1:0]] = xferMemAddr;
      xt[nX[1:0]] = terminalCountFlag;
      nX++;
    end
  end
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    cmdAddr <= a; cmdWrData <= d; cmdWr <= 1'b1;
    @(posedge clk);
    cmdWr <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    cmdAddr <= a; cmdRd <= 1'b1;
    @(posedge clk);
    cmdRd <= 1'b0;
    #1 d = cmdRdData;
  endtask : rd
  // Two idle edges keep clear of the host's busy window after a fetch
  task devrd(output logic [7:0] d);
    wr(2'h2, 8'h00);
    repeat (2) @(posedge clk);
    rd(2'h1, d);
  endtask : devrd
  task wrn(input logic [7:0] s, input int n, input logic [23:0] v);
    wr(2'h0, s);
    for (int i = 0; i < n; i++) wr(2'h1, v[i*8 +: 8]);
  endtask : wrn
  task rdn(input logic [7:0] s, input int n, input logic [31:0] e);
    logic [7:0] b;
    logic [31:0] v;
    v = 32'h0;
    wr(2'h0, s);
    for (int i = 0; i < n; i++) begin
      devrd(b);
      v[i*8 +: 8] = b;
    end
    `CHK("readback", e, v)
  endtask : rdn
  task runx(input logic [7:0] req, input logic [7:0] un, input int want);
    nX = 0;
    chanReq <= req;
    wr(2'h0, un);
    for (int i = 0; i < 30 && nX < want; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1 `CHK("xfers", want, nX)
  endtask : runx
  task t_ch2;
    wr(2'h0, 8'h92);
    @(posedge clk);
    #1 `CHK("mask", 8'hFF, chanMask)
    wrn(8'h22, 3, 24'h332211);
    rdn(8'h32, 4, 32'h00332211);
    wrn(8'h42, 2, 24'h0001);
    rdn(8'h52, 2, 32'h0001);
    wrn(8'h72, 1, 24'h4D);
    rdn(8'h72, 1, 32'h4D);
    wrn(8'h02, 2, 24'h1234);
    rdn(8'h02, 2, 32'h1234);
    runx(8'h04, 8'hA2, 2);
    `CHK("addr0", 24'h332211, xa[0])
    `CHK("addr1", 24'h332213, xa[1])
    `CHK("tc", 2'b01, {xt[0], xt[1]})
    `CHK("io", 16'h1234, xferIoAddr)
    `CHK("dir", 4'hC, {xferWide, xferWriteMem, xferVerify, 1'b0})
    `CHK("id", 7'h22, {xferChan, arbId})
    `CHK("remask", 8'hFF, chanMask)
    rdn(8'h62, 1, 32'h44);
    rdn(8'h62, 1, 32'h00);
  endtask : t_ch2
  task t_ch0;
    wrn(8'h80, 1, 24'h05);
    rdn(8'h80, 1, 32'h05);
    wrn(8'h70, 1, 24'h00);
    wrn(8'h00, 2, 24'h5678);
    wrn(8'h40, 2, 24'h0000);
    runx(8'h01, 8'hA0, 1);
    `CHK("tc0", 1'b1, xt[0])
    `CHK("io0", 16'h0000, xferIoAddr)
    `CHK("dir0", 3'b001, {xferWide, xferWriteMem, xferVerify})
    `CHK("arb0", 4'h5, arbId)
  endtask : t_ch0
  task t_misc;
    logic [7:0] st;
    rdn(8'h12, 1, 32'h00);
    // Level command on a channel without a level is refused by the host
    wr(2'h0, 8'h81);
    rd(2'h3, st);
    `CHK("errch", 8'h06, st)
    wr(2'h3, 8'h00);
    rd(2'h3, st);
    `CHK("errclr", 8'h02, st)
    // Reserved level F never reaches the controller
    wr(2'h0, 8'h80);
    wr(2'h1, 8'h0F);
    rd(2'h3, st);
    `CHK("errF", 8'h06, st)
    wr(2'h3, 8'h00);
    rdn(8'h80, 1, 32'h05);
    wr(2'h0, 8'hA4);
    @(posedge clk);
    #1 `CHK("clr4", 8'hEF, chanMask)
    wr(2'h0, 8'hAB);
    @(posedge clk);
    #1 `CHK("clr3", 8'hE7, chanMask)
    wr(2'h0, 8'hD0);
    @(posedge clk);
    #1 `CHK("mclr", 8'hFF, chanMask)
  endtask : t_misc
  task closeOut;
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : closeOut
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 `CHK("rstmask", 8'hFF, chanMask)
    t_ch2();
    t_ch0();
    t_misc();
    closeOut();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    nFail++;
    closeOut();
  end
endmodule : tb
